// ### hw/pio_pkg.sv
package pio_pkg;

   // Register byte offsets on the APB port.
   localparam logic [11:0] PIO_OFF_CTRL = 12'h000;
   localparam logic [11:0] PIO_OFF_STATUS = 12'h004;

   // CTRL fields.
   localparam int PIO_CTRL_MODE_POS = 0;
   localparam int PIO_CTRL_MODE_W = 2;
   localparam logic [1:0] PIO_CTRL_MODE_RST = 2'h2;

   // STATUS fields.
   localparam int PIO_STAT_DIN_HI_POS = 0;
   localparam int PIO_STAT_DIN_LO_POS = 1;
   localparam int PIO_STAT_OE_POS = 2;
   localparam int PIO_STAT_PAD_OUT_POS = 3;
   localparam int PIO_STAT_LEVEL_POS = 4;

   localparam logic [31:0] PIO_RDATA_RST = 32'h0000_0000;

   // Order fixes the CTRL mode encoding: 0 input, 1 output, 2 bidirectional, 3 off.
   typedef enum logic [1:0] {
      PIO_MODE_IN,
      PIO_MODE_OUT,
      PIO_MODE_BIDIR,
      PIO_MODE_OFF
   } pio_mode_t;

endpackage

// ### hw/pio_cell.sv
// Behaviour
// - One shared clear/preset source for all registers.
// - Each cell chooses preset or clear function.
// - Registers come up at configured level. The code resets the falling output half to 0.
// - Low power-up level: asynchronous control clears.
// - High power-up level: asynchronous control presets. The code clears the falling output half instead.
// - Synchronous reset acts on active clock edge.
// - Six registers give double-data-rate on both edges.
// - Modes: DDR input, DDR output, bidirectional.
// - Two input registers capture on alternating edges.
// - Latch holds high-phase bit, aligning both bits.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module pio_cell
   import pio_pkg::*;
#(
   parameter bit PWR_UP_HIGH = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   input wire logic dout_a,
   input wire logic dout_b,
   input wire logic oe_req,
   input wire logic ce_in,
   input wire logic ce_out,
   input wire logic sclr,
   input wire logic aclr,
   output logic din_hi,
   output logic din_lo
);

   // The power-up level is a build-time choice, so every cell register resets to a constant.
   localparam logic LVL = PWR_UP_HIGH;

   // The mode field must hold every mode code, or decode and reset would disagree.
   if (PIO_CTRL_MODE_W != $bits(pio_mode_t)) begin : g_mode_w_check
      $error("mode field width does not match the mode type");
   end

   // Register bank on APB.
   pio_mode_t mode_q, mode_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic setup_ph, access_ph, ctrl_sel, stat_sel;

   // Cell registers.
   logic arst_n;
   logic cap_pos_q, cap_pos_d, cap_neg_q, cap_neg_d, lat_q, lat_d;
   logic din_hi_q, din_hi_d, din_lo_q, din_lo_d;
   logic out_pos_q, out_pos_d, out_neg_q, out_neg_d;
   logic oe_pos_q, oe_pos_d, oe_neg_q, oe_neg_d;
   logic in_on, out_drv;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready_q;

   always_comb begin
      ctrl_sel = 1'b0;
      stat_sel = 1'b0;
      if (paddr == PIO_OFF_CTRL) begin
         ctrl_sel = 1'b1;
      end else if (paddr == PIO_OFF_STATUS) begin
         stat_sel = 1'b1;
      end
   end

   // Every access gets exactly one wait-free access cycle; the answer is prepared in setup.
   always_comb begin
      mode_d = mode_q;
      pready_d = setup_ph;
      pslverr_d = 1'b0;
      prdata_d = PIO_RDATA_RST;
      if (setup_ph) begin
         pslverr_d = ~(ctrl_sel | stat_sel);
         if (!pwrite && ctrl_sel) begin
            prdata_d[PIO_CTRL_MODE_POS +: PIO_CTRL_MODE_W] = mode_q;
         end else if (!pwrite && stat_sel) begin
            prdata_d[PIO_STAT_DIN_HI_POS] = din_hi_q;
            prdata_d[PIO_STAT_DIN_LO_POS] = din_lo_q;
            prdata_d[PIO_STAT_OE_POS] = pad_oe;
            prdata_d[PIO_STAT_PAD_OUT_POS] = pad_out;
            prdata_d[PIO_STAT_LEVEL_POS] = LVL;
         end
      end
      if (access_ph && pwrite && ctrl_sel) begin
         mode_d = pio_mode_t'(pwdata[PIO_CTRL_MODE_POS +: PIO_CTRL_MODE_W]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= pio_mode_t'(PIO_CTRL_MODE_RST);
         prdata_q <= PIO_RDATA_RST;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   // The answer stands one cycle, so a stretched access cannot write twice.
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // One async source feeds all cell registers; gating it with the array line keeps it immediate.
   assign arst_n = presetn & ~aclr;

   // Capture enable gates only the aligned outputs; the edge flops keep sampling the pin.
   // Mode code 3 parks the cell: it neither drives the pad nor updates the captured bits.
   assign in_on = ce_in & ((mode_q == PIO_MODE_IN) | (mode_q == PIO_MODE_BIDIR));
   assign out_drv = (mode_q == PIO_MODE_OUT) | ((mode_q == PIO_MODE_BIDIR) & oe_req);

   // Rising-edge registers: input capture, realignment, output and enable halves.
   always_comb begin
      cap_pos_d = pad_in;
      din_hi_d = in_on ? lat_q : din_hi_q;
      din_lo_d = in_on ? cap_neg_q : din_lo_q;
      out_pos_d = ce_out ? (dout_a ^ out_neg_q) : out_pos_q;
      oe_pos_d = out_drv;
      // The output half cancels its partner, so the pad shows the level on this edge.
      if (sclr) begin
         cap_pos_d = LVL;
         din_hi_d = LVL;
         din_lo_d = LVL;
         out_pos_d = LVL ^ out_neg_q;
         oe_pos_d = LVL;
      end
   end

   always_ff @(posedge pclk or negedge arst_n) begin
      if (!arst_n) begin
         cap_pos_q <= LVL;
         din_hi_q <= LVL;
         din_lo_q <= LVL;
         out_pos_q <= LVL;
         oe_pos_q <= LVL;
      end else begin
         cap_pos_q <= cap_pos_d;
         din_hi_q <= din_hi_d;
         din_lo_q <= din_lo_d;
         out_pos_q <= out_pos_d;
         oe_pos_q <= oe_pos_d;
      end
   end

   // Falling-edge registers. The holding stage keeps the rising-edge bit through the low phase.
   always_comb begin
      cap_neg_d = pad_in;
      lat_d = cap_pos_q;
      out_neg_d = ce_out ? (dout_b ^ out_pos_q) : out_neg_q;
      oe_neg_d = oe_pos_q;
      // Same cancelling trick as the rising half keeps the pad at the level.
      if (sclr) begin
         cap_neg_d = LVL;
         lat_d = LVL;
         out_neg_d = LVL ^ out_pos_q;
         oe_neg_d = LVL;
      end
   end

   // The falling output half resets to zero so the pad value (the XOR) equals the level.
   always_ff @(negedge pclk or negedge arst_n) begin
      if (!arst_n) begin
         cap_neg_q <= LVL;
         lat_q <= LVL;
         out_neg_q <= 1'b0;
         oe_neg_q <= LVL;
      end else begin
         cap_neg_q <= cap_neg_d;
         lat_q <= lat_d;
         out_neg_q <= out_neg_d;
         oe_neg_q <= oe_neg_d;
      end
   end

   // The XOR pair switches the pad on each edge without a clock-driven mux, avoiding glitches.
   assign pad_out = out_pos_q ^ out_neg_q;
   // Enable turns on half a cycle late but off at once, so turnaround never overlaps.
   assign pad_oe = oe_pos_q & oe_neg_q;
   assign din_hi = din_hi_q;
   assign din_lo = din_lo_q;

   // Helper samples for checks on the falling edge.
   logic chk_ce_q, chk_a_q, chk_sclr_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_ce_q <= 1'b0;
         chk_a_q <= 1'b0;
         chk_sclr_q <= 1'b1;
      end else begin
         chk_ce_q <= ce_out;
         chk_a_q <= dout_a;
         chk_sclr_q <= sclr;
      end
   end

   // Clear, preset and reset checks.
   a_reset_level: assert property (@(posedge pclk)
      $rose(presetn) |-> din_hi == LVL && din_lo == LVL && pad_out == LVL)
      else $error("cell registers not at power-up level after reset");

   a_aclr_force: assert property (@(posedge pclk) disable iff (!presetn)
      aclr |-> din_hi == LVL && din_lo == LVL && pad_out == LVL && lat_q == LVL)
      else $error("asynchronous control did not force the level");

   a_aclr_enable: assert property (@(posedge pclk) disable iff (!presetn)
      aclr |-> pad_oe == LVL && cap_pos_q == LVL && cap_neg_q == LVL)
      else $error("asynchronous control missed a cell register");

   a_sclr_sync: assert property (@(posedge pclk) disable iff (!arst_n)
      sclr && in_on |=> din_hi == LVL && din_lo == LVL
         && out_pos_q == (LVL ^ $past(out_neg_q)))
      else $error("synchronous reset lost to data");

   // Input capture checks.
   a_hold_stage: assert property (@(posedge pclk) disable iff (!arst_n)
      !sclr |-> lat_q == cap_pos_q)
      else $error("holding stage lost the rising-edge bit");

   a_din_align: assert property (@(posedge pclk) disable iff (!arst_n)
      in_on && !sclr |=> din_hi == $past(lat_q) && din_lo == $past(cap_neg_q))
      else $error("input bits not aligned to one edge");

   a_din_hold: assert property (@(posedge pclk) disable iff (!arst_n)
      !in_on && !sclr |=> $stable(din_hi) && $stable(din_lo))
      else $error("input bits moved while capture was off");

   // Output and enable checks.
   a_ddr_out_rise: assert property (@(negedge pclk) disable iff (!arst_n)
      chk_ce_q && !chk_sclr_q |-> pad_out == chk_a_q)
      else $error("rising half of output not on pad");

   a_ddr_out_fall: assert property (@(posedge pclk) disable iff (!arst_n)
      ce_out && !sclr |-> pad_out == dout_b)
      else $error("falling half of output not on pad");

   a_out_hold: assert property (@(posedge pclk) disable iff (!arst_n)
      !ce_out && !sclr ##1 !ce_out && !sclr |-> $stable(pad_out))
      else $error("pad value moved while output capture was off");

   a_input_no_drive: assert property (@(posedge pclk) disable iff (!arst_n || sclr)
      mode_q == PIO_MODE_IN |=> !pad_oe)
      else $error("pad driven in input mode");

   a_out_drives: assert property (@(posedge pclk) disable iff (!arst_n)
      mode_q == PIO_MODE_OUT && !sclr ##1 mode_q == PIO_MODE_OUT && !sclr ##1 !sclr |-> pad_oe)
      else $error("pad not driven in output mode");

   a_bidir_oe_off: assert property (@(posedge pclk) disable iff (!arst_n)
      mode_q == PIO_MODE_BIDIR && !oe_req && !sclr |=> !pad_oe)
      else $error("pad still driven after the bidirectional enable dropped");

   // Register port checks.
   a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph && !ctrl_sel && !stat_sel |=> pready && pslverr)
      else $error("unmapped address not refused");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph |=> pready ##1 !pready)
      else $error("register port did not answer in one access cycle");

   a_apb_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph && (ctrl_sel || stat_sel) |=> pready && !pslverr)
      else $error("mapped address refused");

   a_stat_level: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph && !pwrite && stat_sel |=> prdata[PIO_STAT_LEVEL_POS] == LVL)
      else $error("status does not show the power-up level");

   a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
      access_ph && pwrite && ctrl_sel |=> mode_q == pio_mode_t'($past(pwdata[1:0])))
      else $error("mode write not taken");

   // Main scenarios.
   c_ddr_input: cover property (@(posedge pclk) disable iff (!arst_n)
      in_on ##1 in_on && din_hi != din_lo);
   c_bidir_turn: cover property (@(posedge pclk) disable iff (!arst_n)
      mode_q == PIO_MODE_BIDIR && pad_oe ##[1:20] !pad_oe);
   c_sync_reset: cover property (@(posedge pclk) disable iff (!arst_n) sclr && ce_out);
   c_async_clear: cover property (@(posedge pclk) disable iff (!presetn) aclr);
   c_apb_error: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);

endmodule // pio_cell

`default_nettype wire

// ### testbench/pio_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_array_model (
   input wire logic pclk,
   output logic dout_a,
   output logic dout_b,
   output logic oe_req,
   output logic ce_in,
   output logic ce_out,
   output logic sclr,
   output logic aclr
);
   initial {dout_a, dout_b, oe_req, ce_in, ce_out, sclr, aclr} = 7'h00;
   // One clear line feeds every cell register, so the cell never sees split sources.
   task automatic drive(input logic [6:0] v);
      @(posedge pclk);
      {dout_a, dout_b, oe_req, ce_in, ce_out, sclr, aclr} <= v;
   endtask
endmodule // pio_array_model
`default_nettype wire

// ### testbench/test_io_element_ddr_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_io_element_ddr_registers;
   import pio_pkg::*;
   typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} pio_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pad_in, pad_out, pad_oe;
   logic dout_a, dout_b, oe_req, ce_in, ce_out, sclr, aclr, din_hi, din_lo;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   int err_count = 0;
   int total_checks = 0;
   pio_row_t rows [6] = '{
      '{12'h000, 1'b1, 32'h1, 32'h0, 1'b0}, '{12'h000, 1'b0, 32'h0, 32'h1, 1'b0},
      '{12'h004, 1'b1, 32'hff, 32'h0, 1'b0}, '{12'h008, 1'b0, 32'h0, 32'h0, 1'b1},
      '{12'h000, 1'b1, 32'h3, 32'h0, 1'b0}, '{12'h000, 1'b0, 32'h0, 32'h3, 1'b0}};
   pio_cell pio_cell_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .dout_a(dout_a), .dout_b(dout_b), .oe_req(oe_req), .ce_in(ce_in), .ce_out(ce_out),
      .sclr(sclr), .aclr(aclr), .din_hi(din_hi), .din_lo(din_lo));
   pio_array_model pio_array_model_inst (.pclk(pclk), .dout_a(dout_a), .dout_b(dout_b),
      .oe_req(oe_req), .ce_in(ce_in), .ce_out(ce_out), .sclr(sclr), .aclr(aclr));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The wait is bounded so a stuck slave ends in the verdict rather than a hang.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, pad_in} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(PIO_OFF_CTRL, 1'b0, 32'h0);
      chk(rd, {30'h0, PIO_CTRL_MODE_RST});
      apb(PIO_OFF_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h0);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].x);
         chk({31'h0, er}, {31'h0, rows[i].e});
      end
      apb(PIO_OFF_CTRL, 1'b1, 32'h0);
      pio_array_model_inst.drive(7'h08);
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         pad_in <= 1'(k == 0);
         @(posedge pclk);
         pad_in <= 1'(k == 1);
         @(posedge pclk);
         #1 chk({din_hi, din_lo}, {31'h0, k == 0} << 1 | (k == 1));
      end
      pio_array_model_inst.drive(7'h00);
      pad_in <= 1'b0;
      repeat (3) @(posedge pclk);
      #1 chk({din_hi, din_lo}, 32'h3);
      pio_array_model_inst.drive(7'h0e);
      pad_in <= 1'b1;
      repeat (3) @(posedge pclk);
      #1 chk({din_hi, din_lo}, 32'h0);
      apb(PIO_OFF_CTRL, 1'b1, 32'h1);
      for (int k = 0; k < 2; k++) begin
         pio_array_model_inst.drive(k == 0 ? 7'h44 : 7'h24);
         @(posedge pclk);
         #2 chk(pad_out, 1'(k == 0));
         #5 chk(pad_out, 1'(k == 1));
      end
      chk(pad_oe, 1'b1);
      apb(PIO_OFF_CTRL, 1'b1, 32'h2);
      pio_array_model_inst.drive(7'h10);
      repeat (2) @(posedge pclk);
      #1 chk(pad_oe, 1'b1);
      pio_array_model_inst.drive(7'h00);
      @(posedge pclk);
      #1 chk(pad_oe, 1'b0);
      pio_array_model_inst.drive(7'h45);
      #1 chk({pad_out, pad_oe, din_hi, din_lo}, 32'h0);
      repeat (2) @(posedge pclk);
      #1 chk({pad_out, pad_oe, din_hi, din_lo}, 32'h0);
      tally_and_finish();
   end
endmodule // test_io_element_ddr_registers
`default_nettype wire
